//--- mqf_pkg.sv
// Summary of operation
// - four areas: coils rw, discrete inputs ro, input registers ro, holding registers rw.
// - eight function codes: four reads, two single writes, two multiple writes; the framer builds only the reads and single writes.
// - read query is address, function, start high/low, count high/low, then CRC.
// - coil read uses function 01H with start coil and coil count.
// - discrete input read uses function 02H with start input and count.
// - holding register read uses 03H; answer has byte count, then registers high first.
// - input register read uses 04H; registers return high then low after count.
// - single coil force uses 05H; value FF00 is on, 0000 is off.
// - single register preset uses 06H, address then value, both high byte first.
// - protocol address is point number minus one; point 00001 maps to zero.
// - answer with a different function code and a good CRC is flagged with error 0x0C.
// - answer failing the CRC check is flagged with error 0x0A.
package mqf_pkg;

  // function codes
  localparam logic [7:0] FC_RD_COILS = 8'h01;
  localparam logic [7:0] FC_RD_DISC  = 8'h02;
  localparam logic [7:0] FC_RD_HOLD  = 8'h03;
  localparam logic [7:0] FC_RD_INPUT = 8'h04;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  // multiple writes are known codes but not built by this framer
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;

  localparam logic [15:0] COIL_ON_VAL  = 16'hFF00;
  localparam logic [15:0] COIL_OFF_VAL = 16'h0000;
  localparam logic [15:0] PT_BASE      = 16'h0001;

  // result codes
  localparam logic [7:0] ERR_NONE    = 8'h00;
  localparam logic [7:0] ERR_CRC     = 8'h0A;
  localparam logic [7:0] ERR_FC      = 8'h0C;
  localparam logic [7:0] ERR_ECHO    = 8'h0D;
  localparam logic [7:0] ERR_LEN     = 8'h0E;
  localparam logic [7:0] ERR_TIMEOUT = 8'h0F;

  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;

  // frame layout
  localparam int QRY_BYTES   = 6;
  localparam int FRAME_BYTES = 8;
  localparam int IDX_FC      = 1;
  localparam int IDX_BCNT    = 2;
  localparam int IDX_DATA    = 3;
  localparam int RD_OVERHEAD = 5;
  localparam int RX_CNT_W    = 9;

  // answer timeout
  localparam int CLK_MHZ         = 200;
  localparam int RSP_TIMEOUT_US  = 1000;
  localparam int RSP_TIMEOUT_CYC = RSP_TIMEOUT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    OP_RD_COILS,
    OP_RD_DISC,
    OP_RD_HOLD,
    OP_RD_INPUT,
    OP_WR_COIL,
    OP_WR_REG
  } mqf_op_t;

  typedef struct packed {
    mqf_op_t     op;
    logic [7:0]  slave;
    logic [15:0] point;
    logic [15:0] value;
    logic        coil_on;
  } mqf_cmd_t;

  typedef struct packed {
    logic       err;
    logic [7:0] code;
  } mqf_rsl_t;

endpackage

//--- mqf_crc16.sv
`timescale 1ns/1ps
module mqf_crc16 (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        init,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc,
  output logic      [15:0] crc_nxt
);

  logic [15:0] crc_ff;

  // reflected crc, one byte per cycle
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ mqf_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  always_comb begin
    crc_nxt = crc_step(crc_ff, data);
  end

  // init wins over en so a new frame never inherits old state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      crc_ff <= mqf_pkg::CRC_INIT;
    end else if (init) begin
      crc_ff <= mqf_pkg::CRC_INIT;
    end else if (en) begin
      crc_ff <= crc_nxt;
    end
  end

  assign crc = crc_ff;

endmodule

//--- mqf_pt_map.sv
`timescale 1ns/1ps
module mqf_pt_map (
  input  wire mqf_pkg::mqf_op_t op,
  input  wire logic [15:0]      point,
  input  wire logic [15:0]      value,
  input  wire logic             coil_on,
  output logic      [7:0]       fc,
  output logic      [15:0]      addr,
  output logic      [15:0]      field
);

  // point 00001 of each area is protocol address zero
  always_comb begin
    addr = point - mqf_pkg::PT_BASE;
  end

  // area and access kind pick the code; count or value goes in the field
  always_comb begin
    fc    = mqf_pkg::FC_RD_COILS;
    field = value;
    case (op)
      mqf_pkg::OP_RD_COILS: fc = mqf_pkg::FC_RD_COILS;
      mqf_pkg::OP_RD_DISC:  fc = mqf_pkg::FC_RD_DISC;
      mqf_pkg::OP_RD_HOLD:  fc = mqf_pkg::FC_RD_HOLD;
      mqf_pkg::OP_RD_INPUT: fc = mqf_pkg::FC_RD_INPUT;
      mqf_pkg::OP_WR_COIL: begin
        fc    = mqf_pkg::FC_WR_COIL;
        field = coil_on ? mqf_pkg::COIL_ON_VAL : mqf_pkg::COIL_OFF_VAL;
      end
      mqf_pkg::OP_WR_REG:   fc = mqf_pkg::FC_WR_REG;
      default:              fc = mqf_pkg::FC_RD_COILS;
    endcase
  end

endmodule

//--- mqf_query_framer.sv
`timescale 1ns/1ps
module mqf_query_framer #(
  parameter int RSP_TIMEOUT_CYC = mqf_pkg::RSP_TIMEOUT_CYC
) (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire mqf_pkg::mqf_cmd_t cmd,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  output logic     [7:0]         tx_data,
  output logic                   tx_valid,
  input  wire logic              tx_ready,
  input  wire logic [7:0]        rx_data,
  input  wire logic              rx_valid,
  input  wire logic              rx_end,
  output logic     [7:0]         rsp_data,
  output logic                   rsp_valid,
  output logic                   done,
  output mqf_pkg::mqf_rsl_t      result
);

  localparam int TMO_W = $clog2(RSP_TIMEOUT_CYC + 1);
  localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(RSP_TIMEOUT_CYC - 1);
  localparam logic [2:0] TX_LAST_QRY = 3'(mqf_pkg::QRY_BYTES - 1);
  localparam logic [2:0] TX_CRC_HI   = 3'(mqf_pkg::QRY_BYTES);
  localparam logic [2:0] TX_LAST     = 3'(mqf_pkg::FRAME_BYTES - 1);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_FC   = mqf_pkg::RX_CNT_W'(mqf_pkg::IDX_FC);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_BCNT = mqf_pkg::RX_CNT_W'(mqf_pkg::IDX_BCNT);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_DATA = mqf_pkg::RX_CNT_W'(mqf_pkg::IDX_DATA);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_OVH  = mqf_pkg::RX_CNT_W'(mqf_pkg::RD_OVERHEAD);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_WLEN = mqf_pkg::RX_CNT_W'(mqf_pkg::FRAME_BYTES);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_QLEN = mqf_pkg::RX_CNT_W'(mqf_pkg::QRY_BYTES);
  localparam logic [mqf_pkg::RX_CNT_W-1:0] RX_MAX  = '1;

  if (RSP_TIMEOUT_CYC < 2) begin : g_bad_timeout
    $error("answer timeout must be at least two cycles");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT, ST_SKIP} mqf_state_t;

  mqf_state_t                  state_ff;
  logic [7:0]                  qry_ff [mqf_pkg::QRY_BYTES];
  logic [2:0]                  tx_idx_ff;
  logic [7:0]                  tx_data_ff;
  logic                        tx_valid_ff;
  logic                        cmd_ready_ff;
  logic                        is_read_ff;
  logic [mqf_pkg::RX_CNT_W-1:0] rx_cnt_ff;
  logic [7:0]                  bcnt_ff;
  logic                        fc_bad_ff;
  logic                        echo_bad_ff;
  logic [TMO_W-1:0]            tmo_ff;
  logic [7:0]                  rsp_data_ff;
  logic                        rsp_valid_ff;
  logic                        done_ff;
  mqf_pkg::mqf_rsl_t           result_ff;
  mqf_pkg::mqf_rsl_t           nxt_result;

  logic        cmd_hs;
  logic        tx_hs;
  logic        rx_take;
  logic        rx_foreign;
  logic        frame_end;
  logic        tmo_hit;
  logic        crc_init;
  logic        crc_en;
  logic [7:0]  crc_data;
  logic [15:0] crc_val;
  logic [15:0] crc_nxt;
  logic [7:0]  map_fc;
  logic [15:0] map_addr;
  logic [15:0] map_field;
  logic [mqf_pkg::RX_CNT_W-1:0] rd_len;

  mqf_pt_map u_map (
    .op      (cmd.op),
    .point   (cmd.point),
    .value   (cmd.value),
    .coil_on (cmd.coil_on),
    .fc      (map_fc),
    .addr    (map_addr),
    .field   (map_field)
  );

  // one engine serves both directions since they never overlap
  mqf_crc16 u_crc (
    .clk     (clk),
    .arst_n  (arst_n),
    .init    (crc_init),
    .en      (crc_en),
    .data    (crc_data),
    .crc     (crc_val),
    .crc_nxt (crc_nxt)
  );

  // handshakes and frame events
  assign cmd_hs     = cmd_valid & cmd_ready_ff;
  assign tx_hs      = tx_valid_ff & tx_ready;
  assign rx_foreign = (rx_cnt_ff == '0) & (rx_data != qry_ff[0]);
  assign rx_take    = (state_ff == ST_WAIT) & rx_valid & ~rx_foreign;
  assign frame_end  = (state_ff == ST_WAIT) & rx_end & (rx_cnt_ff != '0);
  assign tmo_hit    = ((state_ff == ST_WAIT && rx_cnt_ff == '0) || state_ff == ST_SKIP)
                      && tmo_ff == TMO_LAST;
  assign rd_len     = mqf_pkg::RX_CNT_W'(bcnt_ff) + RX_OVH;
  assign crc_data   = (state_ff == ST_SEND) ? tx_data_ff : rx_data;
  assign crc_en     = ((state_ff == ST_SEND) & tx_hs & (tx_idx_ff <= TX_LAST_QRY))
                      | rx_take;
  assign crc_init   = cmd_hs | (tx_hs & (tx_idx_ff == TX_LAST))
                      | ((state_ff == ST_SKIP) & rx_end);

  // crc residue of a whole good frame is zero, so it is checked first
  always_comb begin
    nxt_result = '{err: 1'b0, code: mqf_pkg::ERR_NONE};
    if (crc_val != 16'h0000) begin
      nxt_result = '{err: 1'b1, code: mqf_pkg::ERR_CRC};
    end else if (fc_bad_ff) begin
      nxt_result = '{err: 1'b1, code: mqf_pkg::ERR_FC};
    end else if (is_read_ff ? (rx_cnt_ff != rd_len) : (rx_cnt_ff != RX_WLEN)) begin
      nxt_result = '{err: 1'b1, code: mqf_pkg::ERR_LEN};
    end else if (echo_bad_ff) begin
      nxt_result = '{err: 1'b1, code: mqf_pkg::ERR_ECHO};
    end
  end

  // main sequence
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: if (cmd_hs) state_ff <= ST_SEND;
        ST_SEND: if (tx_hs && tx_idx_ff == TX_LAST) state_ff <= ST_WAIT;
        ST_WAIT: begin
          if (frame_end || tmo_hit) begin
            state_ff <= ST_IDLE;
          end else if (rx_valid && rx_foreign) begin
            state_ff <= ST_SKIP;
          end
        end
        ST_SKIP: begin
          if (tmo_hit) begin
            state_ff <= ST_IDLE;
          end else if (rx_end) begin
            state_ff <= ST_WAIT;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // registered ready so the command port sees a clean level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ready_ff <= 1'b1;
    end else if (cmd_hs) begin
      cmd_ready_ff <= 1'b0;
    end else if (frame_end || tmo_hit) begin
      cmd_ready_ff <= 1'b1;
    end
  end

  // query image, kept for the echo compare
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < mqf_pkg::QRY_BYTES; i++) begin
        qry_ff[i] <= 8'h00;
      end
      is_read_ff <= 1'b0;
    end else if (cmd_hs) begin
      qry_ff[0]  <= cmd.slave;
      qry_ff[1]  <= map_fc;
      qry_ff[2]  <= map_addr[15:8];
      qry_ff[3]  <= map_addr[7:0];
      qry_ff[4]  <= map_field[15:8];
      qry_ff[5]  <= map_field[7:0];
      is_read_ff <= (cmd.op != mqf_pkg::OP_WR_COIL) && (cmd.op != mqf_pkg::OP_WR_REG);
    end
  end

  // byte feeder; crc low goes out first, taken from the live next value
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_data_ff  <= 8'h00;
      tx_valid_ff <= 1'b0;
      tx_idx_ff   <= 3'h0;
    end else if (cmd_hs) begin
      tx_data_ff  <= cmd.slave;
      tx_valid_ff <= 1'b1;
      tx_idx_ff   <= 3'h0;
    end else if (tx_hs) begin
      tx_idx_ff <= tx_idx_ff + 3'h1;
      if (tx_idx_ff < TX_LAST_QRY) begin
        tx_data_ff <= qry_ff[tx_idx_ff + 3'h1];
      end else if (tx_idx_ff == TX_LAST_QRY) begin
        tx_data_ff <= crc_nxt[7:0];
      end else if (tx_idx_ff == TX_CRC_HI) begin
        tx_data_ff <= crc_val[15:8];
      end else begin
        tx_valid_ff <= 1'b0;
      end
    end
  end

  // receive bookkeeping; a foreign frame leaves no trace
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_cnt_ff   <= '0;
      bcnt_ff     <= 8'h00;
      fc_bad_ff   <= 1'b0;
      echo_bad_ff <= 1'b0;
    end else if (state_ff != ST_WAIT) begin
      rx_cnt_ff   <= '0;
      fc_bad_ff   <= 1'b0;
      echo_bad_ff <= 1'b0;
    end else if (rx_take) begin
      if (rx_cnt_ff != RX_MAX) begin
        rx_cnt_ff <= rx_cnt_ff + 1'b1;
      end
      if (rx_cnt_ff == RX_FC && rx_data != qry_ff[mqf_pkg::IDX_FC]) begin
        fc_bad_ff <= 1'b1;
      end
      if (rx_cnt_ff == RX_BCNT) begin
        bcnt_ff <= rx_data;
      end
      if (!is_read_ff && rx_cnt_ff < RX_QLEN && rx_data != qry_ff[rx_cnt_ff[2:0]]) begin
        echo_bad_ff <= 1'b1;
      end
    end
  end

  // payload bytes pass on in arrival order, high byte of each word first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_data_ff  <= 8'h00;
      rsp_valid_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= rx_take && is_read_ff && !fc_bad_ff && rx_cnt_ff >= RX_DATA
                      && rx_cnt_ff < rd_len - 2'd2;
      if (rx_take) begin
        rsp_data_ff <= rx_data;
      end
    end
  end

  // no-answer watchdog, cleared by each accepted answer byte; foreign bytes do not clear it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tmo_ff <= '0;
    end else if (state_ff == ST_IDLE || state_ff == ST_SEND || rx_take) begin
      tmo_ff <= '0;
    end else if (!tmo_hit) begin
      tmo_ff <= tmo_ff + 1'b1;
    end
  end

  // outcome, one pulse per query
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      done_ff   <= 1'b0;
      result_ff <= '{err: 1'b0, code: mqf_pkg::ERR_NONE};
    end else begin
      done_ff <= frame_end | tmo_hit;
      if (frame_end) begin
        result_ff <= nxt_result;
      end else if (tmo_hit) begin
        result_ff <= '{err: 1'b1, code: mqf_pkg::ERR_TIMEOUT};
      end
    end
  end

  assign cmd_ready = cmd_ready_ff;
  assign tx_data   = tx_data_ff;
  assign tx_valid  = tx_valid_ff;
  assign rsp_data  = rsp_data_ff;
  assign rsp_valid = rsp_valid_ff;
  assign done      = done_ff;
  assign result    = result_ff;

  // checks
  property p_first_byte;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs |=> tx_valid_ff && tx_data_ff == $past(cmd.slave);
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("first byte not slave address");

  property p_fc_coils;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_RD_COILS |=> qry_ff[1] == mqf_pkg::FC_RD_COILS;
  endproperty
  a_fc_coils: assert property (p_fc_coils) else $error("coil read code wrong");

  property p_fc_disc;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_RD_DISC |=> qry_ff[1] == mqf_pkg::FC_RD_DISC;
  endproperty
  a_fc_disc: assert property (p_fc_disc) else $error("input read code wrong");

  property p_fc_hold;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_RD_HOLD
    |=> qry_ff[1] == mqf_pkg::FC_RD_HOLD && {qry_ff[4], qry_ff[5]} == $past(cmd.value);
  endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("holding read query wrong");

  property p_fc_input;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_RD_INPUT |=> qry_ff[1] == mqf_pkg::FC_RD_INPUT;
  endproperty
  a_fc_input: assert property (p_fc_input) else $error("input register code wrong");

  property p_coil_val;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_WR_COIL |=> qry_ff[1] == mqf_pkg::FC_WR_COIL
    && {qry_ff[4], qry_ff[5]} == ($past(cmd.coil_on) ? 16'hFF00 : 16'h0000);
  endproperty
  a_coil_val: assert property (p_coil_val) else $error("coil force value wrong");

  property p_reg_val;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs && cmd.op == mqf_pkg::OP_WR_REG ##1 tx_hs [*6]
    |-> tx_data_ff == $past(cmd.value[7:0], 6)
        && $past(tx_data_ff) == $past(cmd.value[15:8], 6);
  endproperty
  a_reg_val: assert property (p_reg_val) else $error("preset value order wrong");

  property p_addr_map;
    @(posedge clk) disable iff (!arst_n)
    cmd_hs |=> {qry_ff[2], qry_ff[3]} == $past(cmd.point) - 16'h0001;
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("point to address wrong");

  property p_fc_err;
    @(posedge clk) disable iff (!arst_n)
    frame_end && crc_val == 16'h0000 && fc_bad_ff |=> done_ff && result_ff.code == 8'h0C;
  endproperty
  a_fc_err: assert property (p_fc_err) else $error("function mismatch not flagged");

  property p_crc_err;
    @(posedge clk) disable iff (!arst_n)
    frame_end && crc_val != 16'h0000 |=> done_ff && result_ff.err && result_ff.code == 8'h0A;
  endproperty
  a_crc_err: assert property (p_crc_err) else $error("crc error not flagged");

  property p_crc_ok;
    @(posedge clk) disable iff (!arst_n)
    tx_hs && tx_idx_ff == TX_CRC_HI |-> tx_data_ff == crc_val[7:0];
  endproperty
  a_crc_ok: assert property (p_crc_ok) else $error("crc low byte not sent first");

  property p_foreign;
    @(posedge clk) disable iff (!arst_n)
    state_ff == ST_WAIT && rx_valid && rx_foreign && !rx_end
    |=> state_ff == ST_SKIP && !rsp_valid_ff && rx_cnt_ff == '0;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign answer not discarded");

  c_read_ok: cover property (@(posedge clk) disable iff (!arst_n)
    done_ff && !result_ff.err && is_read_ff);
  c_write_ok: cover property (@(posedge clk) disable iff (!arst_n)
    done_ff && !result_ff.err && !is_read_ff);
  c_crc_bad: cover property (@(posedge clk) disable iff (!arst_n)
    done_ff && result_ff.code == mqf_pkg::ERR_CRC);
  c_skip: cover property (@(posedge clk) disable iff (!arst_n)
    state_ff == ST_SKIP ##1 state_ff == ST_WAIT);

endmodule

//--- mqf_slave_model.sv
`timescale 1ns/1ps
module mqf_slave_model (
  input  wire logic       clk,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic      [7:0] rx_data,
  output logic            rx_valid,
  output logic            rx_end,
  input  wire logic [2:0] mode,
  input  wire logic       slow
);
  logic [7:0]  q [0:7];
  logic [7:0]  r [0:31];
  int          n;
  int          len;
  logic [15:0] c;

  // reflected crc, also used by the bench for expected frames
  function automatic logic [15:0] crc16(input logic [7:0] b [0:31], input int k);
    logic [15:0] s;
    s = 16'hFFFF;
    for (int i = 0; i < k; i++) begin
      s = s ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) begin
        s = s[0] ? ((s >> 1) ^ 16'hA001) : (s >> 1);
      end
    end
    return s;
  endfunction

  // mode: 0 good, 1 bad crc, 2 exception, 3 foreign address, 4 silent
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_end   = 1'b0;
    rx_data  = 8'h00;
    forever begin
      n = 0;
      // slow mode toggles ready so every byte after the first must wait
      while (n < 8) begin
        @(posedge clk);
        if (tx_valid && tx_ready) begin
          q[n] = tx_data;
          n++;
        end
        #1 tx_ready = (slow && n < 8) ? ~tx_ready : (n < 8);
      end
      r[0] = q[0] + 8'(mode == 3'd3);
      r[1] = q[1] | ((mode == 3'd2) ? 8'h80 : 8'h00);
      if (mode == 3'd2) begin
        r[2] = 8'h01;
        len  = 3;
      end else if (q[1] < 8'h05) begin
        r[2] = (q[1] < 8'h03) ? 8'(({q[4], q[5]} + 16'h0007) / 8) : 8'({q[4], q[5]} * 2);
        for (int i = 0; i < 32 - 5 && i < int'(r[2]); i++) begin
          r[3 + i] = 8'hA0 + 8'(i);
        end
        len = 3 + int'(r[2]);
      end else begin
        for (int i = 2; i < 6; i++) begin
          r[i] = q[i];
        end
        len = 6;
      end
      c          = crc16(r, len);
      r[len]     = c[7:0] ^ {7'h00, mode == 3'd1};
      r[len + 1] = c[15:8];
      len        = len + 2;
      repeat (3) @(posedge clk);
      #1;
      if (mode != 3'd4) begin
        for (int i = 0; i < len; i++) begin
          rx_valid = 1'b1;
          rx_data  = r[i];
          @(posedge clk);
          #1;
        end
        rx_valid = 1'b0;
        rx_data  = ~rx_data; // no stale byte once the line is released
        rx_end   = 1'b1;
        @(posedge clk);
        #1 rx_end = 1'b0;
      end
    end
  end
endmodule

//--- tb_mqf_query_framer.sv
`timescale 1ns/1ps
module tb_mqf_query_framer;
  logic               clk;
  logic               arst_n;
  mqf_pkg::mqf_cmd_t  cmd;
  logic               cmd_valid;
  logic               cmd_ready;
  logic [7:0]         tx_data;
  logic               tx_valid;
  logic               tx_ready;
  logic [7:0]         rx_data;
  logic               rx_valid;
  logic               rx_end;
  logic [7:0]         rsp_data;
  logic               rsp_valid;
  logic               done;
  mqf_pkg::mqf_rsl_t  result;
  logic [2:0]         mode;
  logic               slow;
  int                 err_count;
  int                 compares;
  logic [7:0]         pay [$];

  // short timeout keeps silent-slave cases brief
  mqf_query_framer #(.RSP_TIMEOUT_CYC(64)) u_mqf_query_framer (
    .clk(clk), .arst_n(arst_n), .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_end(rx_end), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .done(done), .result(result));

  mqf_slave_model u_mqf_slave_model (
    .clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .mode(mode), .slow(slow));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // collect forwarded payload bytes
  always @(posedge clk) begin
    if (rsp_valid === 1'b1) begin
      pay.push_back(rsp_data);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t ns: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one query to slave 11h, then frame, result and payload checks
  task automatic query(input mqf_pkg::mqf_op_t op, input logic [15:0] pt,
                       input logic [15:0] val, input logic on, input logic [2:0] md,
                       input logic [7:0] code);
    int          k;
    logic [7:0]  e [0:31];
    logic [15:0] c;
    logic [15:0] fld;
    logic [15:0] adr;
    mode = md;
    pay.delete();
    cmd = '{op: op, slave: 8'h11, point: pt, value: val, coil_on: on};
    cmd_valid = 1'b1;
    @(posedge clk);
    #1 cmd_valid = 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 600);
    if (k >= 600) begin
      err_count++;
      print_verdict();
    end
    fld  = (op == mqf_pkg::OP_WR_COIL) ? (on ? 16'hFF00 : 16'h0000) : val;
    adr  = pt - 16'h0001;
    e[0] = 8'h11;
    e[1] = {5'h00, op} + 8'h01;
    e[2] = adr[15:8];
    e[3] = adr[7:0];
    e[4] = fld[15:8];
    e[5] = fld[7:0];
    c    = u_mqf_slave_model.crc16(e, 6);
    e[6] = c[7:0];
    e[7] = c[15:8];
    for (int i = 0; i < 8; i++) begin
      chk({8'h00, u_mqf_slave_model.q[i]}, {8'h00, e[i]});
    end
    chk({7'h00, result.err, result.code}, {7'h00, code != 8'h00, code});
    if (md == 3'd0 && op < mqf_pkg::OP_WR_COIL) begin
      k = (op < mqf_pkg::OP_RD_HOLD) ? (int'(val) + 7) / 8 : int'(val) * 2;
      chk(16'(pay.size()), 16'(k));
      foreach (pay[i]) begin
        chk({8'h00, pay[i]}, {8'h00, 8'hA0 + 8'(i)});
      end
    end
    if (md == 3'd2 || md == 3'd3) begin
      chk(16'(pay.size()), 16'h0000);
    end
  endtask

  task automatic t_reads();
    query(mqf_pkg::OP_RD_COILS, 16'h0014, 16'h0025, 1'b0, 3'd0, 8'h00);
    query(mqf_pkg::OP_RD_DISC, 16'h00C5, 16'h0016, 1'b0, 3'd0, 8'h00);
    query(mqf_pkg::OP_RD_INPUT, 16'h0001, 16'h0001, 1'b0, 3'd0, 8'h00);
    $display("test reads done");
  endtask

  task automatic t_slow_hold();
    slow = 1'b1;
    query(mqf_pkg::OP_RD_HOLD, 16'h006C, 16'h0003, 1'b0, 3'd0, 8'h00);
    slow = 1'b0;
    $display("test slow_hold done");
  endtask

  task automatic t_writes();
    query(mqf_pkg::OP_WR_COIL, 16'h00AD, 16'h1234, 1'b1, 3'd0, 8'h00);
    query(mqf_pkg::OP_WR_COIL, 16'h00AD, 16'h1234, 1'b0, 3'd0, 8'h00);
    query(mqf_pkg::OP_WR_REG, 16'h0088, 16'h039E, 1'b0, 3'd0, 8'h00);
    $display("test writes done");
  endtask

  task automatic t_faults();
    query(mqf_pkg::OP_RD_HOLD, 16'h0002, 16'h0001, 1'b0, 3'd1, 8'h0A);
    query(mqf_pkg::OP_RD_COILS, 16'h0002, 16'h0008, 1'b0, 3'd2, 8'h0C);
    query(mqf_pkg::OP_WR_REG, 16'h0003, 16'h00FF, 1'b0, 3'd1, 8'h0A);
    query(mqf_pkg::OP_RD_INPUT, 16'h0004, 16'h0002, 1'b0, 3'd3, 8'h0F);
    query(mqf_pkg::OP_RD_DISC, 16'h0005, 16'h0001, 1'b0, 3'd4, 8'h0F);
    $display("test faults done");
  endtask

  initial begin
    arst_n    = 1'b0;
    cmd       = '0;
    cmd_valid = 1'b0;
    mode      = 3'd0;
    slow      = 1'b0;
    err_count = 0;
    compares  = 0;
    repeat (8) @(posedge clk);
    #1 arst_n = 1'b1;
    chk({15'h0000, cmd_ready}, 16'h0001);
    chk({13'h0000, tx_valid, rsp_valid, done}, 16'h0000);
    t_reads();
    t_slow_hold();
    t_writes();
    t_faults();
    print_verdict();
  end
endmodule
